// ==== core/tdm_port_pkg.sv ====
package tdm_port_pkg;
    // ------------------------------------------------------------
    // register map (byte addresses, word index in wb_adr_i[4:2])
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_CTRL = 3'h0;
    localparam logic [2:0] IDX_STATUS = 3'h1;
    localparam logic [2:0] IDX_MASK = 3'h2;
    localparam logic [2:0] IDX_TX_DATA = 3'h3;
    localparam logic [2:0] IDX_RX_DATA = 3'h4;
    localparam logic [2:0] IDX_IC_TX = 3'h5;
    localparam logic [2:0] IDX_IC_RX = 3'h6;
    localparam logic [2:0] IDX_CFG = 3'h7;
    // field positions
    localparam int CTRL_TX_EN = 0;
    localparam int CTRL_IC_REV = 1;
    localparam int EV_FRAME = 0;
    localparam int EV_RX_DONE = 1;
    localparam int EV_DEACT = 2;
    localparam int EV_W = 3;
    // ------------------------------------------------------------
    // frame geometry, in bit slots (one bit = two clock periods)
    // ------------------------------------------------------------
    localparam logic [8:0] TE_SLOT_BITS = 9'h008;
    localparam logic [8:0] LC_SLOT_BITS = 9'h020;
    localparam logic [8:0] LC_PAIR_BITS = 9'h008;
    localparam logic [8:0] IC_FIRST_BIT = 9'h040;
    localparam logic [8:0] IC_BITS = 9'h010;
    localparam logic [8:0] BYTE_BITS = 9'h008;
    localparam logic TERMINAL_MODE = 1'b0;
    localparam logic LINECARD_MODE = 1'b1;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int DEACT_NS = 2000;
    localparam int DEACT_CYC_I = DEACT_NS / CLK_PERIOD_NS;
    localparam logic [9:0] DEACT_CYC = 10'(DEACT_CYC_I);
    localparam logic [9:0] RESET_WORD10 = 10'h000;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_HALF = 16'h0000;

    // latched pin configuration
    typedef struct packed {
        logic linecard;
        logic [2:0] slot;
        logic pair_sel;
    } cfg_t;
endpackage

// ==== core/tdm_slave_port_pins.sv ====
// Design decisions made here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module tdm_slave_port_pins (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // serial bus pins
    input wire logic frame_sync_in_i,
    input wire logic bus_bit_clock_i,
    input wire logic downstream_line_i,
    output logic downstream_line_o,
    output logic downstream_line_oe_o,
    input wire logic upstream_line_i,
    output logic upstream_line_o,
    output logic upstream_line_oe_o,
    // static configuration pins
    input wire logic terminal_linecard_sel_i,
    input wire logic slot_addr_bit0_i,
    input wire logic slot_addr_bit1_i,
    input wire logic slot_addr_bit2_i,
    input wire logic chip_pair_select_i,
    // open-drain interrupt
    output logic int_req_n_o,
    output logic int_req_n_oe_o
);
    import tdm_port_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [8:0] sync1;
        logic [8:0] sync2;
        logic clk_d;
        logic fsc_d;
        logic [9:0] cnt;
        logic [9:0] idle;
        logic active;
        cfg_t cfg;
        logic [1:0] ctrl;
        logic [EV_W-1:0] status;
        logic [EV_W-1:0] mask;
        logic [7:0] tx_data;
        logic [7:0] rx_data;
        logic [7:0] rx_sh;
        logic [15:0] ic_tx;
        logic [15:0] ic_rx;
        logic [15:0] ic_sh;
        logic up_o;
        logic up_oe;
        logic dn_o;
        logic dn_oe;
        logic irq;
        logic ack;
        logic [31:0] rdata;
    } state_t;

    state_t st_r, st_nxt;

    // own byte: terminal slot*8, line card slot*32 + pair*8
    function automatic logic [8:0] own_start(input cfg_t c);
        logic [8:0] s;
        s = 9'(c.slot) * TE_SLOT_BITS;
        if (c.linecard) begin
            s = 9'(c.slot) * LC_SLOT_BITS;
            if (c.pair_sel) begin
                s = s + LC_PAIR_BITS;
            end
        end
        return s;
    endfunction

    function automatic logic own_hit(input logic [8:0] b, input cfg_t c);
        return (b >= own_start(c)) && (b < own_start(c) + BYTE_BITS);
    endfunction

    function automatic logic ic_hit(input logic [8:0] b);
        return (b >= IC_FIRST_BIT) && (b < IC_FIRST_BIT + IC_BITS);
    endfunction

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic [7:0] pins;
    logic bus_bit_clock, frame_sync_in, rise, fall, frame_go, rev, wr, rd_ack;
    logic [9:0] cnt_n;
    logic [8:0] bit_n, bit_c, pos_o, pos_i;
    logic [EV_W-1:0] ev;

    assign pins = {chip_pair_select_i, slot_addr_bit2_i, slot_addr_bit1_i,
                   slot_addr_bit0_i, terminal_linecard_sel_i,
                   upstream_line_i, downstream_line_i, frame_sync_in_i};

    always_comb begin
        st_nxt = st_r;
        // two-flop synchronisers; stage one feeds stage two only
        // bits: 0 bit clock, 1 frame sync, 2 downstream, 3 upstream,
        // 4 mode, 7:5 slot address, 8 pair select
        st_nxt.sync1 = {pins, bus_bit_clock_i};
        st_nxt.sync2 = st_r.sync1;
        bus_bit_clock = st_r.sync2[0];
        frame_sync_in = st_r.sync2[1];
        st_nxt.clk_d = bus_bit_clock;
        // timing derives only from the controller's clock edges
        rise = bus_bit_clock && !st_r.clk_d;
        fall = !bus_bit_clock && st_r.clk_d;
        frame_go = 1'b0;
        ev = '0;
        cnt_n = st_r.cnt;
        // bus idle detection: clock parked at either level for DEACT_CYC cycles means deactivated
        if (rise || fall) begin
            st_nxt.idle = RESET_WORD10;
        end else if (st_r.idle < DEACT_CYC) begin
            st_nxt.idle = st_r.idle + 10'h001;
        end
        st_nxt.active = (st_nxt.idle < DEACT_CYC);
        if (st_r.active && !st_nxt.active) begin
            ev[EV_DEACT] = 1'b1;
        end
        // config only follows pins while bus is idle
        if (!st_r.active) begin
            st_nxt.cfg.linecard = st_r.sync2[4] ? LINECARD_MODE
                                                : TERMINAL_MODE;
            st_nxt.cfg.slot = st_r.sync2[7:5];
            st_nxt.cfg.pair_sel = st_r.sync2[8] & st_r.sync2[4];
        end
        rev = st_r.ctrl[CTRL_IC_REV] && !st_r.cfg.linecard;
        // frame counter, restarted by sync sampled on a rising edge
        if (rise) begin
            st_nxt.fsc_d = frame_sync_in;
            frame_go = frame_sync_in && !st_r.fsc_d;
            cnt_n = frame_go ? RESET_WORD10 : st_r.cnt + 10'h001;
            ev[EV_FRAME] = frame_go;
            st_nxt.cnt = cnt_n;
        end
        bit_n = cnt_n[9:1];
        bit_c = st_r.cnt[9:1];
        pos_o = bit_n - own_start(st_r.cfg);
        // drive lines at the start of each bit period
        if (rise && !cnt_n[0]) begin
            st_nxt.up_oe = st_r.ctrl[CTRL_TX_EN] && own_hit(bit_n, st_r.cfg);
            st_nxt.up_o = st_r.tx_data[3'(7 - pos_o[2:0])];
            pos_o = bit_n - IC_FIRST_BIT;
            st_nxt.dn_oe = rev && ic_hit(bit_n);
            st_nxt.dn_o = st_r.ic_tx[4'(15 - pos_o[3:0])];
        end
        // sample in the second half of each bit
        pos_i = bit_c - own_start(st_r.cfg);
        if (fall && st_r.cnt[0]) begin
            if (own_hit(bit_c, st_r.cfg)) begin
                st_nxt.rx_sh = {st_r.rx_sh[6:0], st_r.sync2[2]};
                if (pos_i[2:0] == 3'h7) begin
                    st_nxt.rx_data = {st_r.rx_sh[6:0], st_r.sync2[2]};
                    ev[EV_RX_DONE] = 1'b1;
                end
            end
            pos_i = bit_c - IC_FIRST_BIT;
            if (ic_hit(bit_c)) begin
                // reversal: intercomm arrives on the upstream line
                st_nxt.ic_sh = {st_r.ic_sh[14:0],
                                rev ? st_r.sync2[3] : st_r.sync2[2]};
                if (pos_i[3:0] == 4'hf) begin
                    st_nxt.ic_rx = st_nxt.ic_sh;
                end
            end
        end
        // released at once when the bus goes down
        if (!st_nxt.active) begin
            st_nxt.up_oe = 1'b0;
            st_nxt.dn_oe = 1'b0;
        end
        // wishbone: one wait state, ack for exactly one cycle
        st_nxt.ack = wb_cyc_i && wb_stb_i && !st_r.ack;
        wr = st_nxt.ack && wb_we_i && wb_sel_i[0];
        rd_ack = st_nxt.ack && !wb_we_i;
        st_nxt.rdata = '0;
        if (rd_ack) begin
            case (wb_adr_i[4:2])
                IDX_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
                IDX_STATUS: st_nxt.rdata = 32'(st_r.status);
                IDX_MASK: st_nxt.rdata = 32'(st_r.mask);
                IDX_TX_DATA: st_nxt.rdata = 32'(st_r.tx_data);
                IDX_RX_DATA: st_nxt.rdata = 32'(st_r.rx_data);
                IDX_IC_TX: st_nxt.rdata = 32'(st_r.ic_tx);
                IDX_IC_RX: st_nxt.rdata = 32'(st_r.ic_rx);
                IDX_CFG: st_nxt.rdata = 32'({st_r.active, st_r.cfg});
                default: st_nxt.rdata = '0;
            endcase
        end
        // sticky events: write one clears, a new event wins
        st_nxt.status = st_r.status;
        if (wr && wb_adr_i[4:2] == IDX_STATUS) begin
            st_nxt.status = st_r.status & ~wb_dat_i[EV_W-1:0];
        end
        st_nxt.status = st_nxt.status | ev;
        if (wr) begin
            case (wb_adr_i[4:2])
                IDX_CTRL: st_nxt.ctrl = wb_dat_i[1:0];
                IDX_MASK: st_nxt.mask = wb_dat_i[EV_W-1:0];
                IDX_TX_DATA: st_nxt.tx_data = wb_dat_i[7:0];
                IDX_IC_TX: begin
                    st_nxt.ic_tx[7:0] = wb_dat_i[7:0];
                    if (wb_sel_i[1]) begin
                        st_nxt.ic_tx[15:8] = wb_dat_i[15:8];
                    end
                end
                default: st_nxt.ctrl = st_nxt.ctrl;
            endcase
        end
        st_nxt.irq = |(st_nxt.status & st_nxt.mask);
    end

    // ------------------------------------------------------------
    // registers; synchronous reset clears everything except idle, which loads DEACT_CYC
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.idle <= DEACT_CYC;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign wb_dat_o = st_r.rdata;
    assign wb_ack_o = st_r.ack;
    assign upstream_line_o = st_r.up_o;
    assign upstream_line_oe_o = st_r.up_oe;
    assign downstream_line_o = st_r.dn_o;
    assign downstream_line_oe_o = st_r.dn_oe;
    assign int_req_n_o = 1'b0;
    assign int_req_n_oe_o = st_r.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_idle_te;
        (!terminal_linecard_sel_i && !st_r.active)[*5];
    endsequence
    sequence s_frame_edge;
        rise && frame_go;
    endsequence

    property p_up_release;
        @(posedge clk_i) disable iff (rst_i)
        !st_r.active |-> !upstream_line_oe_o;
    endproperty
    a_up_release: assert property (p_up_release)
        else $error("upstream driven while bus deactivated");

    property p_dn_only_rev;
        @(posedge clk_i) disable iff (rst_i)
        downstream_line_oe_o |-> st_r.active && !st_r.cfg.linecard
            && st_r.ctrl[CTRL_IC_REV] && ic_hit(st_r.cnt[9:1]);
    endproperty
    a_dn_only_rev: assert property (p_dn_only_rev)
        else $error("downstream driven outside reversed intercomm slot");

    property p_up_own_slot;
        @(posedge clk_i) disable iff (rst_i)
        upstream_line_oe_o |-> own_hit(st_r.cnt[9:1], st_r.cfg);
    endproperty
    a_up_own_slot: assert property (p_up_own_slot)
        else $error("upstream driven outside own slot");

    property p_irq;
        @(posedge clk_i) disable iff (rst_i)
        (|(st_r.status & st_r.mask)) == int_req_n_oe_o && !int_req_n_o;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt line not matching pending events");

    property p_reset;
        @(posedge clk_i)
        rst_i |=> st_r.status == '0 && st_r.ctrl == '0
            && !upstream_line_oe_o && !int_req_n_oe_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("state not cleared by reset");

    property p_frame;
        @(posedge clk_i) disable iff (rst_i)
        s_frame_edge |=> st_r.cnt == RESET_WORD10 && st_r.status[EV_FRAME];
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame start not restarting the counter");

    property p_timing_slave;
        @(posedge clk_i) disable iff (rst_i)
        $rose(upstream_line_oe_o) |-> $past(rise);
    endproperty
    a_timing_slave: assert property (p_timing_slave)
        else $error("upstream drive not tied to a clock edge");

    property p_cfg_static;
        @(posedge clk_i) disable iff (rst_i)
        st_r.active && $past(st_r.active) |-> $stable(st_r.cfg);
    endproperty
    a_cfg_static: assert property (p_cfg_static)
        else $error("configuration changed during active bus");

    property p_mode_te;
        @(posedge clk_i) disable iff (rst_i)
        s_idle_te |=> st_r.cfg.linecard == TERMINAL_MODE;
    endproperty
    a_mode_te: assert property (p_mode_te)
        else $error("low mode pin did not select terminal mode");

    // a bus that drops must leave the deactivation event behind
    property p_deact_event;
        @(posedge clk_i) disable iff (rst_i)
        st_r.active ##1 !st_r.active |-> st_r.status[EV_DEACT];
    endproperty
    a_deact_event: assert property (p_deact_event)
        else $error("bus drop did not flag deactivation");

    // one answer per request: ack never stands two cycles
    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("wishbone ack held longer than one cycle");
endmodule

// ==== tb/tdm_ctrl_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------
// upstream controller: frame sync, bit clock, data
// ----------------------------------------------------
module tdm_ctrl_model #(
    parameter int FRAME_BITS = 96
) (
    // bus pins
    output logic frame_sync_o,
    output logic bit_clock_o,
    output logic dn_o,
    output logic dn_oe_o,
    input wire logic dn_wire_i,
    input wire logic dn_dev_oe_i,
    input wire logic up_wire_i,
    input wire logic up_oe_i,
    // scenario settings and results
    input wire logic [8:0] pos_i,
    input wire logic [7:0] dn_byte_i,
    output logic [7:0] up_byte_o,
    output logic [15:0] ic_seen_o,
    output int up_cnt_o,
    output logic dn_seen_o
);
    int b;
    // clock stands low and data released outside frames
    initial begin
        frame_sync_o = 1'b0;
        bit_clock_o = 1'b0;
        dn_o = 1'b0;
        dn_oe_o = 1'b0;
    end
    // frame shortened to keep the run short; bit = two periods
    task automatic run_frame();
        up_cnt_o = 0;
        dn_seen_o = 1'b0;
        for (int e = 0; e < 2 * FRAME_BITS; e++) begin
            b = e / 2;
            frame_sync_o = (b == 0);
            dn_oe_o = (b >= pos_i && b < pos_i + 8);
            if (dn_oe_o) begin
                dn_o = dn_byte_i[7 - (b - pos_i)];
            end
            #20 bit_clock_o = 1'b1;
            #40 bit_clock_o = 1'b0;
            // sample at the falling edge of the bit's second period
            if (e % 2 == 1) begin
                if (dn_oe_o) begin
                    up_byte_o[7 - (b - pos_i)] = up_wire_i;
                end
                if (up_oe_i) begin
                    up_cnt_o++;
                end
                if (b >= 64 && b < 80) begin
                    ic_seen_o[79 - b] = dn_wire_i;
                end
                if (dn_dev_oe_i) begin
                    dn_seen_o = 1'b1;
                end
            end
            #20;
        end
        frame_sync_o = 1'b0;
        dn_oe_o = 1'b0;
    endtask
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------
// port bench
// ----------------------------------------------------
module tb_top;
    import tdm_port_pkg::*;
    logic clk_i, rst_i, cyc, stb, we, ack, fs, bclk, dn_m, dn_m_oe;
    logic dn_d, dn_d_oe, up_d, up_d_oe, dn_wire, up_wire, int_n, int_oe;
    logic mode_pin, pair_pin, dn_seen;
    logic [2:0] slot_pin;
    logic [3:0] sel;
    logic [4:0] adr;
    logic [31:0] dat_w, dat_r, q;
    logic [8:0] pos;
    logic [7:0] dn_byte, up_byte;
    logic [15:0] ic_seen;
    int up_cnt;
    int errors = 0;
    int compares = 0;
    // pull-ups on both data lines
    assign dn_wire = dn_d_oe ? dn_d : (dn_m_oe ? dn_m : 1'b1);
    assign up_wire = up_d_oe ? up_d : 1'b1;
    tdm_slave_port_pins uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat_w), .wb_dat_o(dat_r), .wb_ack_o(ack),
        .frame_sync_in_i(fs), .bus_bit_clock_i(bclk),
        .downstream_line_i(dn_wire), .downstream_line_o(dn_d),
        .downstream_line_oe_o(dn_d_oe), .upstream_line_i(up_wire),
        .upstream_line_o(up_d), .upstream_line_oe_o(up_d_oe),
        .terminal_linecard_sel_i(mode_pin), .slot_addr_bit0_i(slot_pin[0]),
        .slot_addr_bit1_i(slot_pin[1]), .slot_addr_bit2_i(slot_pin[2]),
        .chip_pair_select_i(pair_pin), .int_req_n_o(int_n),
        .int_req_n_oe_o(int_oe));
    tdm_ctrl_model m (.frame_sync_o(fs), .bit_clock_o(bclk), .dn_o(dn_m),
        .dn_oe_o(dn_m_oe), .dn_wire_i(dn_wire), .dn_dev_oe_i(dn_d_oe),
        .up_wire_i(up_wire), .up_oe_i(up_d_oe), .pos_i(pos),
        .dn_byte_i(dn_byte), .up_byte_o(up_byte), .ic_seen_o(ic_seen),
        .up_cnt_o(up_cnt), .dn_seen_o(dn_seen));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // classic cycle; waits for ack, only the watchdog ends a hang
    task automatic wb(input logic w, input logic [2:0] idx,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        dat_w <= d;
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] idx, input logic [31:0] exp,
                      input string name);
        wb(1'b0, idx, 32'h0000_0000);
        check(name, q, exp);
    endtask
    // pins only latch while the bus is idle
    task automatic pins(input logic md, input logic [2:0] sl, input logic pr);
        @(posedge clk_i);
        mode_pin <= md;
        slot_pin <= sl;
        pair_pin <= pr;
        repeat (8) @(posedge clk_i);
    endtask
    task automatic test_reset();
        check("up_oe", up_d_oe, 0);
        check("dn_oe", dn_d_oe, 0);
        check("int_oe", int_oe, 0);
        for (int i = 0; i < 8; i++) rd(3'(i), 0, "reg");
    endtask
    task automatic test_terminal();
        logic a;
        pins(TERMINAL_MODE, 3'h3, 1'b1);
        rd(IDX_CFG, 32'h0000_0006, "cfg");
        wb(1'b1, IDX_TX_DATA, 32'h0000_00a5);
        wb(1'b1, IDX_CTRL, 32'h0000_0001);
        wb(1'b1, IDX_MASK, 32'h0000_0000);
        pos = 9'h018;
        dn_byte = 8'h3c;
        m.run_frame();
        m.run_frame();
        check("up_byte", up_byte, 8'ha5);
        check("up_bits", up_cnt, 8);
        check("dn_drive", dn_seen, 0);
        rd(IDX_RX_DATA, 32'h0000_003c, "rx");
        wb(1'b0, IDX_STATUS, 32'h0000_0000);
        check("status", q & 32'h0000_0003, 32'h0000_0003);
        repeat (3) @(posedge clk_i);
        a = int_oe;
        wb(1'b1, IDX_MASK, 32'h0000_0007);
        repeat (3) @(posedge clk_i);
        check("int_masked", a, 0);
        check("int_mask", int_oe, 1);
        wb(1'b1, IDX_STATUS, 32'h0000_0007);
        repeat (3) @(posedge clk_i);
        check("int_clr", int_oe, 0);
        check("int_n", int_n, 0);
    endtask
    task automatic test_deact();
        repeat (600) @(posedge clk_i);
        check("up_idle", up_d_oe, 0);
        check("dn_idle", dn_d_oe, 0);
        wb(1'b0, IDX_STATUS, 32'h0000_0000);
        check("deact", q[EV_DEACT], 1);
        wb(1'b0, IDX_CFG, 32'h0000_0000);
        check("active", q[5], 0);
        wb(1'b1, IDX_STATUS, 32'h0000_0007);
    endtask
    task automatic test_linecard();
        pins(LINECARD_MODE, 3'h1, 1'b1);
        rd(IDX_CFG, 32'h0000_0013, "cfg_lc");
        wb(1'b1, IDX_TX_DATA, 32'h0000_0096);
        pos = 9'h028;
        dn_byte = 8'h69;
        m.run_frame();
        m.run_frame();
        check("up_lc", up_byte, 8'h96);
        check("bits_lc", up_cnt, 8);
        rd(IDX_RX_DATA, 32'h0000_0069, "rx_lc");
    endtask
    task automatic test_reverse();
        repeat (600) @(posedge clk_i);
        pins(TERMINAL_MODE, 3'h0, 1'b0);
        wb(1'b1, IDX_IC_TX, 32'h0000_beef);
        wb(1'b1, IDX_CTRL, 32'h0000_0003);
        pos = 9'h000;
        dn_byte = 8'h5a;
        m.run_frame();
        m.run_frame();
        check("ic_down", ic_seen, 16'hbeef);
        check("dn_rev", dn_seen, 1);
        check("up_slot0", up_byte, 8'h96);
        rd(IDX_RX_DATA, 32'h0000_005a, "rx_slot0");
        rd(IDX_IC_RX, 32'h0000_ffff, "ic_up");
    endtask
    task automatic test_done();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        test_done();
    end
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, mode_pin, pair_pin} = 5'h00;
        adr = 5'h00;
        sel = 4'hf;
        dat_w = 32'h0000_0000;
        slot_pin = 3'h0;
        pos = 9'h000;
        dn_byte = 8'h00;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        test_reset();
        test_terminal();
        test_deact();
        test_linecard();
        test_reverse();
        test_done();
    end
endmodule
